// *** rtl/obbg_border_blink.v ***
`timescale 1ns/1ps
`include "obbg_regs.vh"
// Function
// - A border dot appears where the dot is clear and one of its eight neighbours is set.
// - No border is drawn above a character dot that sits in the top dot row of its cell.
// - No border is drawn below a character dot that sits in the bottom dot row of its cell.
// - A character's dots in its leftmost column never put a border to their left.
// - Dots in column twelve put a border into the next position unless that position is off.
// - At position twenty-four the right-hand border of column twelve dots is dropped.
// - Each character position blinks only when its own blink enable is set.
// - A border dot lying in another character's area never blinks.
// - The blink enable and colour of the character under the dot travel with that dot.
// - The background style and colour select border drawing and give its colour.
// - The blink ratio times the on and off phases of blinking characters.
module obbg_border_blink (
  input wire sys_clk,
  input wire reset_n,
  input wire dot_valid,
  input wire frame_start,
  input wire [8:0] dot_window,
  input wire [3:0] dot_col,
  input wire [4:0] dot_row,
  input wire [4:0] char_col,
  input wire char_on,
  input wire char_blink,
  input wire char_red,
  input wire char_green,
  input wire char_blue,
  input wire background_style_hi,
  input wire background_style_lo,
  input wire background_red,
  input wire background_green,
  input wire background_blue,
  input wire blink_ratio_hi,
  input wire blink_ratio_lo,
  output reg char_dot,
  output reg border_dot,
  output reg [2:0] char_rgb,
  output reg [2:0] border_rgb,
  output reg dot_out_valid
);
  // Window layout: bits 8..6 row above (left, mid, right), 5..3 this row, 2..0 row below.
  // The caller presents neighbour windows across cell and line edges; no line store is kept here.
  reg [`OBBG_BLINK_CNT_W-1:0] blink_cnt;
  reg [`OBBG_BLINK_CNT_W-1:0] next_blink_cnt;
  reg blink_on;
  reg border_style;
  reg use_above;
  reg use_below;
  reg use_left;
  reg use_right;
  reg [2:0] row_above;
  reg [2:0] row_here;
  reg [2:0] row_below;
  reg own_above;
  reg own_here;
  reg own_below;
  reg own_hit;
  reg left_hit;
  reg border_raw;
  reg from_left;
  reg char_visible;
  reg border_visible;
  reg next_char_dot;
  reg next_border_dot;
  reg [2:0] next_char_rgb;
  reg [2:0] next_border_rgb;
  reg next_dot_out_valid;
  wire [1:0] style;
  wire [1:0] ratio;
  wire [2:0] char_colour;
  wire [2:0] back_colour;

  assign style = {background_style_hi, background_style_lo};
  assign ratio = {blink_ratio_hi, blink_ratio_lo};
  assign char_colour = {char_red, char_green, char_blue};
  assign back_colour = {background_red, background_green, background_blue};

  always @* begin
    case (style)
      `OBBG_STYLE_NONE: border_style = 1'b0;
      `OBBG_STYLE_BORDER: border_style = 1'b1;
      `OBBG_STYLE_KNOCKOUT: border_style = 1'b0;
      `OBBG_STYLE_SOLID: border_style = 1'b0;
      default: border_style = 1'b0;
    endcase
  end

  always @* begin
    // A dot in the top row must not reach up into the line above, and vice versa.
    use_above = (dot_row != 5'h00);
    use_below = (dot_row != `OBBG_LAST_ROW);
    // Left neighbours in column 0 are column twelve of the previous character.
    use_left = 1'b1;
    if (dot_col == 4'h0) begin
      use_left = char_on;
      if (char_col == 5'h00) begin
        use_left = 1'b0;
      end
    end
    // Right neighbours in the last column are column 0 of the next character.
    use_right = (dot_col != `OBBG_LAST_COL);
  end

  always @* begin
    row_above = dot_window[8:6];
    row_here = dot_window[5:3];
    row_below = dot_window[2:0];
    if (!use_above) begin
      row_above = 3'h0;
    end
    if (!use_below) begin
      row_below = 3'h0;
    end
    if (!use_left) begin
      row_above[2] = 1'b0;
      row_here[2] = 1'b0;
      row_below[2] = 1'b0;
    end
    if (!use_right) begin
      row_above[0] = 1'b0;
      row_here[0] = 1'b0;
      row_below[0] = 1'b0;
    end
  end

  always @* begin
    own_above = row_above[1] || row_above[0];
    own_here = row_here[0];
    own_below = row_below[1] || row_below[0];
    own_hit = own_above || own_here || own_below;
    left_hit = row_above[2] || row_here[2] || row_below[2];
    border_raw = 1'b0;
    if (border_style && !dot_window[4]) begin
      border_raw = own_hit || left_hit;
    end
    // A border owed only to the previous character lies outside that character's area.
    from_left = (dot_col == 4'h0) && !own_hit;
  end

  always @* begin
    case (ratio)
      `OBBG_RATIO_1_1: blink_on = !blink_cnt[4];
      `OBBG_RATIO_3_1: blink_on = (blink_cnt[4:3] != 2'h3);
      `OBBG_RATIO_1_3: blink_on = (blink_cnt[4:3] == 2'h0);
      `OBBG_RATIO_STEADY: blink_on = 1'b1;
      default: blink_on = 1'b1;
    endcase
  end

  always @* begin
    next_blink_cnt = blink_cnt;
    if (frame_start) begin
      next_blink_cnt = blink_cnt + 5'h01;
    end
  end

  // Blanking hides the whole character and any border it owns, so blinking stays legible.
  always @* begin
    char_visible = !char_blink || blink_on;
    border_visible = from_left || !char_blink || blink_on;
  end

  always @* begin
    next_dot_out_valid = dot_valid;
    next_char_dot = 1'b0;
    next_border_dot = 1'b0;
    if (dot_valid) begin
      next_char_dot = char_on && dot_window[4] && char_visible;
      next_border_dot = border_raw && border_visible;
    end
    next_char_rgb = char_colour;
    next_border_rgb = back_colour;
  end

  // Every output is registered, so a dot's result shows one clock after it is presented.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_cnt <= {`OBBG_BLINK_CNT_W{1'b0}};
    end else begin
      blink_cnt <= next_blink_cnt;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dot_out_valid <= 1'b0;
    end else begin
      dot_out_valid <= next_dot_out_valid;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      char_dot <= 1'b0;
    end else begin
      char_dot <= next_char_dot;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      border_dot <= 1'b0;
    end else begin
      border_dot <= next_border_dot;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      char_rgb <= 3'h0;
    end else begin
      char_rgb <= next_char_rgb;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      border_rgb <= 3'h0;
    end else begin
      border_rgb <= next_border_rgb;
    end
  end
endmodule // obbg_border_blink

// *** rtl/obbg_regs.vh ***
`ifndef OBBG_REGS_VH
`define OBBG_REGS_VH
`define OBBG_CELL_COLS 4'hC
`define OBBG_CELL_ROWS 5'h12
`define OBBG_LINE_CHARS 5'h18
`define OBBG_LAST_COL 4'hB
`define OBBG_LAST_ROW 5'h11
`define OBBG_LAST_CHAR 5'h17
`define OBBG_STYLE_NONE 2'h0
`define OBBG_STYLE_BORDER 2'h1
`define OBBG_STYLE_KNOCKOUT 2'h2
`define OBBG_STYLE_SOLID 2'h3
`define OBBG_RATIO_1_1 2'h0
`define OBBG_RATIO_3_1 2'h1
`define OBBG_RATIO_1_3 2'h2
`define OBBG_RATIO_STEADY 2'h3
`define OBBG_BLINK_CNT_W 5
`endif

// *** sim/obbg_mcu.sv ***
`timescale 1ns/1ps
module obbg_mcu (
  input wire sys_clk,
  input wire reset_n,
  output reg [6:0] cfg
);
  // A fresh setting every cycle lets each style and ratio meet many dots.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= 7'h00;
    end else begin
      cfg <= cfg + 7'h1B;
    end
  end
endmodule // obbg_mcu

// *** sim/obbg_props_properties.sv ***
`timescale 1ns/1ps
module obbg_props (
  input wire sys_clk,
  input wire reset_n,
  input wire dot_valid,
  input wire char_blink,
  input wire char_on,
  input wire char_dot,
  input wire border_dot,
  input wire background_style_hi,
  input wire background_style_lo,
  input wire [8:0] dot_window,
  input wire [3:0] dot_col,
  input wire [4:0] dot_row,
  input wire [4:0] char_col
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire [8:0] w = dot_window;
  wire b = border_dot;
  wire nb = background_style_hi | !background_style_lo;
  wire lo = dot_row == 5'h11 && !w[8:3];
  wire rc = dot_col == 4'hB && !(w & 9'h1B6);
  wire sp = !dot_col && !(char_on && char_col) && !(w & 9'h0DB);
  wire sd = dot_valid && char_on && w[4] && !char_blink;
  wire sl = dot_valid && !nb && !dot_col && char_on && char_col && w[5] && !(w & 9'h0DB);
  a_idle_dark: assert property (!$past(dot_valid) |-> !char_dot && !b) else $error("idle");
  a_style_gate: assert property ($past(nb) |-> !b) else $error("style");
  a_clear_dot: assert property (b |-> $past(!w[4] && |w)) else $error("clear");
  a_top_row: assert property ($past(!dot_row && !w[5:0]) |-> !b) else $error("top");
  a_low_row: assert property ($past(lo) |-> !b) else $error("low");
  a_right_col: assert property ($past(rc) |-> !b) else $error("right");
  a_spill_off: assert property ($past(sp) |-> !b) else $error("spill");
  a_steady_dot: assert property ($past(sd) |-> char_dot) else $error("steady");
  a_side_steady: assert property ($past(sl) |-> b) else $error("side");
endmodule // obbg_props
bind obbg_border_blink obbg_props obbg_props_i (.*);

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  reg sys_clk = 1'h0;
  reg reset_n = 1'h0;
  reg dot_valid = 1'h0;
  reg [8:0] dot_window = 9'h000;
  reg [3:0] dot_col = 4'h0;
  reg [4:0] dot_row = 5'h00;
  reg [4:0] char_col = 5'h00;
  reg [31:0] r = 32'h7CE5;
  reg [4:0] bc = 5'h00;
  reg e_valid = 1'h0;
  reg e_char = 1'h0;
  reg e_border = 1'h0;
  reg [2:0] e_crgb = 3'h0;
  reg [2:0] e_brgb = 3'h0;
  integer n_fail = 0;
  integer checked = 0;
  integer i;
  wire [6:0] cfg;
  wire char_dot;
  wire border_dot;
  wire dot_out_valid;
  wire [2:0] char_rgb;
  wire [2:0] border_rgb;
  always #5 sys_clk = ~sys_clk;
  obbg_mcu obbg_mcu_i (.sys_clk(sys_clk), .reset_n(reset_n), .cfg(cfg));
  obbg_border_blink obbg_border_blink_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .dot_valid(dot_valid), .frame_start(&r[31:29]), .dot_window(dot_window),
    .dot_col(dot_col), .dot_row(dot_row), .char_col(char_col), .char_on(r[24]),
    .char_blink(r[25]), .char_red(r[26]), .char_green(r[27]), .char_blue(r[28]),
    .background_style_hi(cfg[6]), .background_style_lo(cfg[5]), .background_red(cfg[4]),
    .background_green(cfg[3]), .background_blue(cfg[2]), .blink_ratio_hi(cfg[1]),
    .blink_ratio_lo(cfg[0]), .char_dot(char_dot), .border_dot(border_dot),
    .char_rgb(char_rgb), .border_rgb(border_rgb), .dot_out_valid(dot_out_valid));
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Blink phase over a 32-frame cycle: 1:1, 3:1 and 1:3 on to off, the last code steady.
  function ph_on(input [4:0] n, input [1:0] ratio);
    case (ratio)
      2'h0: ph_on = !n[4];
      2'h1: ph_on = n[4:3] != 2'h3;
      2'h2: ph_on = n[4:3] == 2'h0;
      default: ph_on = 1'h1;
    endcase
  endfunction
  function exp_border(input [8:0] w, input [3:0] c, input [4:0] rw, input [4:0] cc,
    input on, input [1:0] st, input blink, input ph);
    reg [8:0] m;
    begin
      m = w;
      if (rw == 5'h00) m = m & 9'h03F;
      if (rw == 5'h11) m = m & 9'h1F8;
      if (c == 4'hB) m = m & 9'h1B6;
      if (c == 4'h0 && (cc == 5'h00 || !on)) m = m & 9'h0DB;
      exp_border = st == 2'h1 && !w[4] && |(m & 9'h1EF);
      if (c != 4'h0 || |(m & 9'h0DB)) exp_border = exp_border && (!blink || ph);
    end
  endfunction
  task chk(input [47:0] nm, input [2:0] s, input [2:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("wrong value %0s exp %b got %b", nm, e, s);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d fails %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("TEST PASSED"); else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk) reset_n = 1'h1;
    for (i = 0; i < 4000; i = i + 1) begin
      @(negedge sys_clk);
      chk("valid", dot_out_valid, e_valid);
      chk("char", char_dot, e_char);
      chk("border", border_dot, e_border);
      chk("c_rgb", char_rgb, e_crgb);
      chk("b_rgb", border_rgb, e_brgb);
      r = nx(r);
      dot_valid = r[0] | (i < 2);
      dot_window = (i < 2) ? 9'h010 << i : r[9:1];
      dot_col = r[13:10] % 12;
      dot_row = r[18:14] % 18;
      char_col = r[23:19] % 24;
      e_valid = dot_valid;
      e_char = dot_valid & dot_window[4] & r[24] & (!r[25] | ph_on(bc, cfg[1:0]));
      e_border = dot_valid & exp_border(dot_window, dot_col, dot_row, char_col, r[24],
        cfg[6:5], r[25], ph_on(bc, cfg[1:0]));
      e_crgb = {r[26], r[27], r[28]};
      e_brgb = cfg[4:2];
      bc = bc + {4'h0, &r[31:29]};
    end
    finish_test;
  end
endmodule // testbench
